/* File: spc_defines.svh */
// Offsets, reset values, field positions and timing counts of the speech control register file.
// Assumes a 10 MHz reference clock; included by its bare name.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH

// ----------------------------------------------------------------
// Register select codes (sequencer side)
// ----------------------------------------------------------------
`define SPC_SEL_ENTRY0      4'h0
`define SPC_SEL_ENTRY1      4'h1
`define SPC_SEL_ENTRY2      4'h2
`define SPC_SEL_ENTRY3      4'h3
`define SPC_SEL_EN_A        4'h4
`define SPC_SEL_EN_B        4'h5
`define SPC_SEL_PIN_CFG     4'h6
`define SPC_SEL_IND_CTRL    4'h7
`define SPC_SEL_STOP        4'h8
`define SPC_SEL_PAGE        4'h9

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPC_RST_ENTRY       8'h20
`define SPC_RST_MODE        8'hFF
`define SPC_RST_PAGE        8'h00
`define SPC_RST_STOP        8'h1F
`define SPC_RST_EN          8'h33

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SPC_PC_FLASH        7
`define SPC_PC_IND2_SEL     6
`define SPC_PC_LONG_DEB     4
`define SPC_PC_HALT_A_SEL   2
`define SPC_IC_ALTERNATE    5
`define SPC_IC_IND1_SECT    4
`define SPC_IC_IND2_SECT    3
`define SPC_IC_VOL_OFF      2
`define SPC_EN_FALL_LSB     0
`define SPC_EN_RISE_LSB     4

// ----------------------------------------------------------------
// Vectors
// ----------------------------------------------------------------
`define SPC_VEC_POWER_ON    6'h20
`define SPC_VEC_RISE_OFS    6'h04

// ----------------------------------------------------------------
// Timing (clock 10 MHz)
// ----------------------------------------------------------------
`define SPC_CLK_HZ          10000000
`define SPC_POR_MS          160
`define SPC_POR_CYC         ((`SPC_CLK_HZ / 1000) * `SPC_POR_MS)
`define SPC_DEB_LONG_MS     50
`define SPC_DEB_LONG_CYC    ((`SPC_CLK_HZ / 1000) * `SPC_DEB_LONG_MS)
`define SPC_DEB_SHORT_US    400
`define SPC_DEB_SHORT_CYC   ((`SPC_CLK_HZ / 1000000) * `SPC_DEB_SHORT_US)
`define SPC_FLASH_HZ        3
`define SPC_FLASH_HALF_CYC  (`SPC_CLK_HZ / (2 * `SPC_FLASH_HZ))

`endif

/* File: spc_pkg.sv */
// Types shared by the speech control register file.
// Constants live in spc_defines.svh.
package spc_pkg;

	typedef enum logic [1:0] {
		SPC_PAGE_1  = 2'b00,
		SPC_PAGE_8  = 2'b01,
		SPC_PAGE_16 = 2'b10,
		SPC_PAGE_32 = 2'b11
	} spc_page_mode_e;

	// One register load or increment from the sequencer
	typedef struct packed {
		logic       load;
		logic [3:0] sel;
		logic [7:0] data;
		logic       inc;
	} spc_reg_wr_s;

	// Section data from the voice datapath
	typedef struct packed {
		logic ind1;
		logic ind2;
		logic vol;
	} spc_sect_s;

	// Vector request to the sequencer
	typedef struct packed {
		logic       valid;
		logic [5:0] vector;
	} spc_vec_req_s;

endpackage

/* File: spc_trig_debounce.sv */
// Synchroniser and debounce filter for one trigger pin.
// Pin is asynchronous; long or short time selected per cycle.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_trig_debounce (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	// Pin and control
	input  wire logic i_pin,
	input  wire logic i_long,
	// Filtered result
	output logic      o_level,
	output logic      o_fall,
	output logic      o_rise
);

	localparam logic [19:0] LONG_CYC  = 20'(`SPC_DEB_LONG_CYC);
	localparam logic [19:0] SHORT_CYC = 20'(`SPC_DEB_SHORT_CYC);

	logic        meta_ff;
	logic        sync_ff;
	logic [19:0] cnt_ff;
	logic        level_ff;

	// Pins idle high through internal pull-ups
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_ff <= 1'b1;
			sync_ff <= 1'b1;
		end else begin
			meta_ff <= i_pin;
			sync_ff <= meta_ff;
		end
	end

	// Level must hold the whole debounce time before it is accepted
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff   <= 20'h00000;
			level_ff <= 1'b1;
			o_fall   <= 1'b0;
			o_rise   <= 1'b0;
		end else begin
			o_fall <= 1'b0;
			o_rise <= 1'b0;
			if (sync_ff == level_ff) begin
				cnt_ff <= 20'h00000;
			end else if (cnt_ff >= (i_long ? LONG_CYC : SHORT_CYC) - 20'h00001) begin
				cnt_ff   <= 20'h00000;
				level_ff <= sync_ff;
				o_fall   <= ~sync_ff;
				o_rise   <= sync_ff;
			end else begin
				cnt_ff <= cnt_ff + 20'h00001;
			end
		end
	end

	assign o_level = level_ff;

endmodule
`default_nettype wire

/* File: spc_ind_flash.sv */
// Free-running 3 Hz flash phase for the indicator outputs.
// Runs whether or not flashing is selected.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_ind_flash (
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_rstn,
	// Phase
	output logic      o_phase
);

	localparam logic [20:0] HALF_CYC = 21'(`SPC_FLASH_HALF_CYC);

	logic [20:0] cnt_ff;
	logic        phase_ff;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt_ff   <= 21'h000000;
			phase_ff <= 1'b0;
		end else if (cnt_ff == HALF_CYC - 21'h000001) begin
			cnt_ff   <= 21'h000000;
			phase_ff <= ~phase_ff;
		end else begin
			cnt_ff <= cnt_ff + 21'h000001;
		end
	end

	assign o_phase = phase_ff;

endmodule
`default_nettype wire

/* File: spc_reg_file.sv */
// Control register file and trigger vector front end of the speech controller.
// Sequencer writes registers one load per instruction; pins face the board.
//
// Operation
// [R1] After reset wait about 160 ms, then request the power-on vector 32.
// [R2] Coinciding requests served: power-on, then trigger falls before rises, jumps last; logic serves lowest trigger first, its fall before its rise.
// [R3] Reset loads entries 0x20, modes 0xFF, page 0, stop 0x1F, enables set.
// [R4] Pin config bit 7 selects 3 Hz flash or steady indicator drive.
// [R5] Pin config bit 6 makes shared pin second indicator or third halt output.
// [R6] Pin config bit 4 selects 50 ms or 400 us trigger debounce.
// [R7] Pin config bit 2 makes shared pin first halt output or busy.
// [R8] Unused bits of both mode registers are ignored and not stored.
// [R9] Indicator control bit 5 selects alternate or in-step flashing.
// [R10] Indicator control bit 4 enables section control of first indicator.
// [R11] Indicator control bit 3: second indicator from section data or halt C.
// [R12] Indicator control bit 2 set turns volume-following first indicator off.
// [R13] Page bits 0 to 4 select page; mode decides how many are used.
// [R14] Entries per page: 256 for 1 and 8 pages, 128 and 64 otherwise.
// [R15] Page mode is a build parameter, default single page, never written.
// [R16] Enable register low bits enable falls, bits 4 and 5 enable rises.
// [R17] An enabled edge requests its vector; a disabled edge is ignored.
// [R18] Each trigger has separate rise and fall vectors.
// [R19] Stop bits 0 to 4 drive the five halt outputs active high.
// [R20] Four 8-bit entry registers; only the first increments by one.
// [R21] Operating mode, clock and output type are build parameters only.
// [R22] Program must hold an end instruction at entry 32 if unused.
// [R23] Each instruction, register load included, lasts two sample periods.
// [R24] A load takes effect at instruction end and governs the next cycle.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_reg_file
	import spc_pkg::*;
#(
	parameter spc_page_mode_e PAGE_MODE = SPC_PAGE_1,
	parameter bit             HOST_MODE = 1'b0,
	parameter bit             FAST_CLK  = 1'b1,
	parameter bit             PWM_OUT   = 1'b0,
	parameter int             POR_CYC   = `SPC_POR_CYC
) (
	// Clock and reset
	input  wire logic         i_ref_clk,
	input  wire logic         i_rstn,
	// Sequencer
	input  wire spc_pkg::spc_reg_wr_s  i_wr,
	input  wire logic         i_instr_end,
	input  wire logic         i_jump_req,
	input  wire logic [5:0]   i_jump_vec,
	input  wire logic         i_busy,
	input  wire spc_pkg::spc_sect_s    i_sect,
	output spc_pkg::spc_vec_req_s      o_vec,
	output logic [7:0]        o_entry0,
	output logic [7:0]        o_entry1,
	output logic [7:0]        o_entry2,
	output logic [7:0]        o_entry3,
	output logic [4:0]        o_page,
	output logic [8:0]        o_page_entries,
	output logic [1:0]        o_page_mode,
	output logic [2:0]        o_build_opts,
	// Board pins
	input  wire logic [3:0]   i_trig_pin,
	output logic              o_first_indicator_out,
	output logic              o_indicator_or_third_halt_pin,
	output logic              o_first_halt_or_busy_pin,
	output logic              o_halt_b,
	output logic              o_halt_d,
	output logic              o_halt_e,
	output logic [3:0]        o_trig_level
);
	import spc_pkg::*;

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [7:0] entry_ff [4];
	logic [7:0] en_a_ff;
	logic [7:0] en_b_ff;
	logic [7:0] pin_cfg_ff;
	logic [7:0] ind_ctrl_ff;
	logic [4:0] stop_ff;
	logic [4:0] page_ff;
	spc_reg_wr_s wr_hold_ff;
	logic        wr_pend_ff;

	// Load captured at issue, applied when the instruction cycle ends
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_hold_ff <= '0;
			wr_pend_ff <= 1'b0;
		end else if (i_wr.load || i_wr.inc) begin
			wr_hold_ff <= i_wr; // R24
			wr_pend_ff <= 1'b1;
		end else if (i_instr_end) begin
			wr_pend_ff <= 1'b0; // R23
		end
	end

	logic commit;
	assign commit = wr_pend_ff && i_instr_end;

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_entry
			always_ff @(posedge i_ref_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					entry_ff[gi] <= `SPC_RST_ENTRY; // R3
				end else if (commit && wr_hold_ff.load && wr_hold_ff.sel == 4'(gi)) begin
					entry_ff[gi] <= wr_hold_ff.data; // R20
				end else if (gi == 0 && commit && wr_hold_ff.inc) begin
					entry_ff[gi] <= entry_ff[gi] + 8'h01; // R20
				end
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			en_a_ff     <= `SPC_RST_EN; // R3
			en_b_ff     <= `SPC_RST_EN;
			pin_cfg_ff  <= `SPC_RST_MODE;
			ind_ctrl_ff <= `SPC_RST_MODE;
			stop_ff     <= 5'(`SPC_RST_STOP);
			page_ff     <= 5'(`SPC_RST_PAGE);
		end else if (commit && wr_hold_ff.load) begin
			case (wr_hold_ff.sel)
				`SPC_SEL_EN_A:     en_a_ff     <= wr_hold_ff.data & 8'h33; // R16
				`SPC_SEL_EN_B:     en_b_ff     <= wr_hold_ff.data & 8'h33;
				`SPC_SEL_PIN_CFG:  pin_cfg_ff  <= wr_hold_ff.data | 8'h2B; // R8
				`SPC_SEL_IND_CTRL: ind_ctrl_ff <= wr_hold_ff.data | 8'hC3; // R8
				`SPC_SEL_STOP:     stop_ff     <= wr_hold_ff.data[4:0]; // R19
				`SPC_SEL_PAGE:     page_ff     <= wr_hold_ff.data[4:0]; // R13
				default: ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Page mode
	// ----------------------------------------------------------------
	logic [4:0] page_mask;
	logic [8:0] page_entries;
	always_comb begin
		case (PAGE_MODE) // R15
			SPC_PAGE_1: begin
				page_mask    = 5'h00; // R13
				page_entries = 9'h100; // R14
			end
			SPC_PAGE_8: begin
				page_mask    = 5'h07;
				page_entries = 9'h100;
			end
			SPC_PAGE_16: begin
				page_mask    = 5'h0F;
				page_entries = 9'h080;
			end
			SPC_PAGE_32: begin
				page_mask    = 5'h1F;
				page_entries = 9'h040;
			end
			default: begin
				page_mask    = 5'h00;
				page_entries = 9'h100;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// Triggers
	// ----------------------------------------------------------------
	logic [3:0] t_level;
	logic [3:0] t_fall;
	logic [3:0] t_rise;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_trig
			spc_trig_debounce u_deb (
				.i_ref_clk (i_ref_clk),
				.i_rstn    (i_rstn),
				.i_pin     (i_trig_pin[gi]),
				.i_long    (pin_cfg_ff[`SPC_PC_LONG_DEB]), // R6
				.o_level   (t_level[gi]),
				.o_fall    (t_fall[gi]),
				.o_rise    (t_rise[gi])
			);
		end
	endgenerate

	// Enables per trigger: pins 0,1 from register a, pins 2,3 from b
	logic [3:0] fall_en;
	logic [3:0] rise_en;
	assign fall_en = {en_b_ff[1:0], en_a_ff[1:0]}; // R16
	assign rise_en = {en_b_ff[5:4], en_a_ff[5:4]};

	// Pending edges held until the sequencer is told, set wins
	logic [3:0] fall_pend_ff;
	logic [3:0] rise_pend_ff;
	logic [3:0] fall_take;
	logic [3:0] rise_take;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			fall_pend_ff <= 4'h0;
			rise_pend_ff <= 4'h0;
		end else begin
			fall_pend_ff <= (fall_pend_ff & ~fall_take) | (t_fall & fall_en); // R17
			rise_pend_ff <= (rise_pend_ff & ~rise_take) | (t_rise & rise_en); // R17
		end
	end

	// ----------------------------------------------------------------
	// Power-on delay
	// ----------------------------------------------------------------
	logic [21:0] por_cnt_ff;
	logic        por_pend_ff;
	logic        por_done_ff;
	logic        por_take;

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			por_cnt_ff  <= 22'h000000;
			por_done_ff <= 1'b0;
		end else if (!por_done_ff) begin
			if (por_cnt_ff == 22'(POR_CYC - 1)) begin
				por_done_ff <= 1'b1; // R1
			end else begin
				por_cnt_ff <= por_cnt_ff + 22'h000001;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			por_pend_ff <= 1'b0;
		end else if (!por_done_ff && por_cnt_ff == 22'(POR_CYC - 1)) begin
			por_pend_ff <= 1'b1; // R1
		end else if (por_take) begin
			por_pend_ff <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Priority select
	// ----------------------------------------------------------------
	logic       sel_valid;
	logic [5:0] sel_vec;
	always_comb begin
		sel_valid = 1'b1;
		sel_vec   = `SPC_VEC_POWER_ON;
		fall_take = 4'h0;
		rise_take = 4'h0;
		por_take  = 1'b0;
		if (por_pend_ff) begin
			por_take = 1'b1; // R2
		end else begin
			sel_valid = 1'b0;
			for (int k = 3; k >= 0; k--) begin
				if (rise_pend_ff[k]) begin
					sel_valid = 1'b1;
					sel_vec   = 6'(k >= 2 ? k + 6 : k) + `SPC_VEC_RISE_OFS; // R18
					fall_take = 4'h0;
					rise_take = 4'(1 << k);
				end
				if (fall_pend_ff[k]) begin
					sel_valid = 1'b1;
					sel_vec   = 6'(k >= 2 ? k + 6 : k); // R18
					fall_take = 4'(1 << k);
					rise_take = 4'h0;
				end
			end
			if (!sel_valid && i_jump_req) begin
				sel_valid = 1'b1; // R2
				sel_vec   = i_jump_vec;
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_vec <= '0;
		end else begin
			o_vec.valid  <= sel_valid;
			o_vec.vector <= sel_vec;
		end
	end

	// ----------------------------------------------------------------
	// Indicator and halt outputs
	// ----------------------------------------------------------------
	logic flash_ph;
	spc_ind_flash u_flash (
		.i_ref_clk (i_ref_clk),
		.i_rstn    (i_rstn),
		.o_phase   (flash_ph)
	);

	logic ind1_on;
	logic ind2_on;
	logic ind1_drv;
	logic ind2_drv;
	always_comb begin
		ind1_on = (ind_ctrl_ff[`SPC_IC_IND1_SECT] ? i_sect.ind1 : 1'b1) // R10
			& (ind_ctrl_ff[`SPC_IC_VOL_OFF] ? 1'b1 : i_sect.vol); // R12
		ind2_on = ind_ctrl_ff[`SPC_IC_IND2_SECT] ? i_sect.ind2 : stop_ff[2]; // R11
		if (pin_cfg_ff[`SPC_PC_FLASH]) begin
			ind1_drv = ind1_on & flash_ph; // R4
			ind2_drv = ind2_on & (ind_ctrl_ff[`SPC_IC_ALTERNATE] ? ~flash_ph : flash_ph); // R9
		end else begin
			ind1_drv = ind1_on;
			ind2_drv = ind2_on;
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_first_indicator_out         <= 1'b0;
			o_indicator_or_third_halt_pin <= 1'b0;
			o_first_halt_or_busy_pin      <= 1'b0;
			o_halt_b                      <= 1'b0;
			o_halt_d                      <= 1'b0;
			o_halt_e                      <= 1'b0;
		end else begin
			o_first_indicator_out         <= ind1_drv;
			o_indicator_or_third_halt_pin <= pin_cfg_ff[`SPC_PC_IND2_SEL] ? ind2_drv : stop_ff[2]; // R5
			o_first_halt_or_busy_pin      <= pin_cfg_ff[`SPC_PC_HALT_A_SEL] ? stop_ff[0] : i_busy; // R7
			o_halt_b                      <= stop_ff[1]; // R19
			o_halt_d                      <= stop_ff[3];
			o_halt_e                      <= stop_ff[4];
		end
	end

	// ----------------------------------------------------------------
	// Register views for the sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_entry0       <= `SPC_RST_ENTRY;
			o_entry1       <= `SPC_RST_ENTRY;
			o_entry2       <= `SPC_RST_ENTRY;
			o_entry3       <= `SPC_RST_ENTRY;
			o_page         <= 5'h00;
			o_page_entries <= 9'h100;
			o_page_mode    <= 2'h0;
			o_build_opts   <= 3'h0;
			o_trig_level   <= 4'hF;
		end else begin
			o_entry0       <= entry_ff[0];
			o_entry1       <= entry_ff[1];
			o_entry2       <= entry_ff[2];
			o_entry3       <= entry_ff[3];
			o_page         <= page_ff & page_mask; // R13
			o_page_entries <= page_entries; // R14
			o_page_mode    <= PAGE_MODE;
			o_build_opts   <= {HOST_MODE, FAST_CLK, PWM_OUT}; // R21
			o_trig_level   <= t_level;
		end
	end

endmodule
`default_nettype wire

/* File: spc_reg_file_props.sv */
// Concurrent checks on the ports of the speech control register file.
// Assumes one clock domain; bound to every spc_reg_file instance.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"

module spc_reg_file_props
	import spc_pkg::*;
#(
	parameter spc_page_mode_e PAGE_MODE = SPC_PAGE_1,
	parameter bit             HOST_MODE = 1'b0,
	parameter bit             FAST_CLK  = 1'b1,
	parameter bit             PWM_OUT   = 1'b0,
	parameter int             POR_CYC   = 20
) (
	// Clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_rstn,
	// Sequencer
	input  wire spc_pkg::spc_reg_wr_s  i_wr,
	input  wire logic                  i_instr_end,
	input  wire spc_pkg::spc_vec_req_s o_vec,
	input  wire logic [7:0]            o_entry0,
	input  wire logic [7:0]            o_entry1,
	input  wire logic [7:0]            o_entry2,
	input  wire logic [7:0]            o_entry3,
	input  wire logic [4:0]            o_page,
	input  wire logic [8:0]            o_page_entries,
	input  wire logic [1:0]            o_page_mode,
	input  wire logic [2:0]            o_build_opts,
	// Board pins
	input  wire logic                  o_halt_b,
	input  wire logic                  o_halt_d,
	input  wire logic                  o_halt_e
);
	// ----
	// Helper state
	// ----
	localparam logic [4:0] PG_MASK = (PAGE_MODE == SPC_PAGE_8) ? 5'h07 :
		(PAGE_MODE == SPC_PAGE_16) ? 5'h0F : (PAGE_MODE == SPC_PAGE_32) ? 5'h1F : 5'h00;
	localparam logic [8:0] PG_ENT = (PAGE_MODE == SPC_PAGE_16) ? 9'h080 :
		(PAGE_MODE == SPC_PAGE_32) ? 9'h040 : 9'h100;
	logic [20:0] cnt_ff;
	logic [7:0]  data_ff;
	logic [3:0]  sel_ff;
	logic [7:0]  inc_ff;
	logic [7:0]  entry_sel;
	// Saturates, never wraps onto the power-on count
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn)
			cnt_ff <= 21'h0;
		else if (cnt_ff != 21'h1FFFFF)
			cnt_ff <= cnt_ff + 21'h1;
	end
	always_ff @(posedge i_ref_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			data_ff <= 8'h00;
			sel_ff  <= 4'h0;
			inc_ff  <= 8'h00;
		end else if (i_wr.load | i_wr.inc) begin
			data_ff <= i_wr.data;
			sel_ff  <= i_wr.sel;
			inc_ff  <= o_entry0 + 8'h01;
		end
	end
	always_comb begin
		case (sel_ff[1:0])
			2'h0: entry_sel = o_entry0;
			2'h1: entry_sel = o_entry1;
			2'h2: entry_sel = o_entry2;
			default: entry_sel = o_entry3;
		endcase
	end
	// ----
	// Properties
	// ----
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rstn);
	sequence end_s;
		i_instr_end && !i_wr.load && !i_wr.inc;
	endsequence
	sequence stop_ld_s;
		(i_wr.load && !i_wr.inc && i_wr.sel == `SPC_SEL_STOP) ##1 end_s;
	endsequence
	sequence entry_ld_s;
		(i_wr.load && !i_wr.inc && i_wr.sel[3:2] == 2'b00) ##1 end_s;
	endsequence
	sequence inc_s;
		(i_wr.inc && !i_wr.load) ##1 end_s;
	endsequence
	por_vector_a: assert property (cnt_ff == 21'(POR_CYC + 1) |-> o_vec.valid && o_vec.vector == `SPC_VEC_POWER_ON)
		else $error("power-on vector not raised on time");
	early_quiet_a: assert property (cnt_ff <= 21'(POR_CYC) |-> !o_vec.valid)
		else $error("request raised before power-on vector");
	reset_values_a: assert property (cnt_ff == 21'h2 |-> {o_entry0, o_entry3, o_page, o_halt_b, o_halt_e} == {16'h2020, 5'h00, 2'b11})
		else $error("reset value wrong");
	halt_levels_a: assert property (stop_ld_s |-> ##[1:3] {o_halt_e, o_halt_d, o_halt_b} == {data_ff[4], data_ff[3], data_ff[1]})
		else $error("halt outputs do not follow stop load");
	entry_load_a: assert property (entry_ld_s |-> ##[1:3] entry_sel == data_ff)
		else $error("entry register load lost");
	entry_inc_a: assert property (inc_s |-> ##[1:3] o_entry0 == inc_ff)
		else $error("entry increment wrong");
	page_masked_a: assert property ((o_page & ~PG_MASK) == 5'h00)
		else $error("unused page bit visible");
	page_entries_a: assert property (cnt_ff >= 21'h2 |-> o_page_entries == PG_ENT)
		else $error("entries per page wrong");
	page_fixed_a: assert property (cnt_ff >= 21'h2 |-> o_page_mode == 2'(PAGE_MODE))
		else $error("page mode changed");
	build_fixed_a: assert property (cnt_ff >= 21'h2 |-> $stable(o_build_opts) && o_build_opts == {HOST_MODE, FAST_CLK, PWM_OUT})
		else $error("build options wrong");
endmodule

bind spc_reg_file spc_reg_file_props #(.PAGE_MODE(PAGE_MODE), .HOST_MODE(HOST_MODE), .FAST_CLK(FAST_CLK),
	.PWM_OUT(PWM_OUT), .POR_CYC(POR_CYC)) u_props (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wr(i_wr),
	.i_instr_end(i_instr_end), .o_vec(o_vec), .o_entry0(o_entry0), .o_entry1(o_entry1), .o_entry2(o_entry2),
	.o_entry3(o_entry3), .o_page(o_page), .o_page_entries(o_page_entries), .o_page_mode(o_page_mode),
	.o_build_opts(o_build_opts), .o_halt_b(o_halt_b), .o_halt_d(o_halt_d), .o_halt_e(o_halt_e));
`default_nettype wire

/* File: spc_board_model.sv */
// Push-button model for the four trigger pins.
// Open buttons read high through the pin pull-ups; changes land at falling edges.
`timescale 1ns/100ps
`default_nettype none

module spc_board_model (
	// Clock
	input  wire logic i_ref_clk,
	// Buttons
	output logic [3:0] o_trig_pin
);
	logic [3:0] pressed = 4'h0;
	// Pressed button pulls its pin low
	assign o_trig_pin = ~pressed;
	task automatic set_buttons(input logic [3:0] down);
		@(negedge i_ref_clk);
		pressed = down;
	endtask
endmodule
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for the speech control register file.
// Sequencer inputs change at falling edges; the board model drives the triggers.
`timescale 1ns/100ps
`default_nettype none
`include "spc_defines.svh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("wrong value at %0t: got %0h expected %0h", $time, g, e); end end

module testbench;
	import spc_pkg::*;
	localparam int POR = 20;
	localparam int DEB = `SPC_DEB_SHORT_CYC + 200;
	logic          i_ref_clk = 1'b0;
	logic          i_rstn = 1'b0;
	spc_reg_wr_s   i_wr = '0;
	logic          i_instr_end = 1'b0;
	logic          i_jump_req = 1'b0;
	logic [5:0]    i_jump_vec = 6'h00;
	logic          i_busy = 1'b0;
	spc_sect_s     i_sect = '0;
	spc_vec_req_s  o_vec;
	logic [7:0]    e0, e1, e2, e3;
	logic [4:0]    o_page;
	logic [8:0]    pe;
	logic [1:0]    pm;
	logic [2:0]    bo;
	logic [3:0]    trig, lvl;
	logic          ind1, ind2, halt_a, halt_b, halt_d, halt_e;
	int            n_fail = 0;
	int            tests_run = 0;
	int            n;
	always #50 i_ref_clk = ~i_ref_clk;
	spc_reg_file #(.POR_CYC(POR)) dut (.i_ref_clk(i_ref_clk), .i_rstn(i_rstn), .i_wr(i_wr),
		.i_instr_end(i_instr_end), .i_jump_req(i_jump_req), .i_jump_vec(i_jump_vec), .i_busy(i_busy),
		.i_sect(i_sect), .o_vec(o_vec), .o_entry0(e0), .o_entry1(e1), .o_entry2(e2), .o_entry3(e3),
		.o_page(o_page), .o_page_entries(pe), .o_page_mode(pm), .o_build_opts(bo), .i_trig_pin(trig),
		.o_first_indicator_out(ind1), .o_indicator_or_third_halt_pin(ind2), .o_first_halt_or_busy_pin(halt_a),
		.o_halt_b(halt_b), .o_halt_d(halt_d), .o_halt_e(halt_e), .o_trig_level(lvl));
	spc_board_model board (.i_ref_clk(i_ref_clk), .o_trig_pin(trig));
	// ----
	// Shared tasks
	// ----
	task automatic close_out();
		$display("checks %0d, fails %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic settle();
		repeat (2) @(negedge i_ref_clk);
	endtask
	// One load or increment, committed at the next instruction end
	task automatic issue(input logic [3:0] sel, input logic [7:0] data, input logic inc);
		@(negedge i_ref_clk);
		i_wr = '{load: !inc, sel: sel, data: data, inc: inc};
		@(negedge i_ref_clk);
		i_wr = '0;
		i_instr_end = 1'b1;
		@(negedge i_ref_clk);
		i_instr_end = 1'b0;
		settle();
	endtask
	task automatic exp_vec(input logic [5:0] v, output int cyc);
		for (cyc = 0; cyc < DEB && o_vec.valid !== 1'b1; cyc++) @(negedge i_ref_clk);
		if (cyc == DEB) begin
			n_fail++;
			$display("wait for vector ran out at %0t", $time);
			close_out();
		end else begin
			`CHK(o_vec.vector, v)
			@(negedge i_ref_clk);
		end
	endtask
	task automatic no_vec();
		repeat (DEB) begin
			@(negedge i_ref_clk);
			`CHK(o_vec.valid, 1'b0)
		end
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_reset();
		for (n = 0; n <= POR + 5 && o_vec.valid !== 1'b1; n++) @(negedge i_ref_clk);
		`CHK(n, POR + 1)
		`CHK(o_vec.vector, `SPC_VEC_POWER_ON)
		`CHK({e0, e1, e2, e3, o_page, lvl}, {32'h20202020, 5'h00, 4'hF})
		`CHK({halt_a, halt_b, halt_d, halt_e}, 4'hF)
		$display("reset test done");
	endtask
	task automatic t_stop();
		issue(`SPC_SEL_STOP, 8'h15, 1'b0);
		`CHK({halt_e, halt_d, halt_b, halt_a}, 4'b1001)
		issue(`SPC_SEL_STOP, 8'hEA, 1'b0);
		`CHK({halt_e, halt_d, halt_b, halt_a}, 4'b0110)
		$display("stop test done");
	endtask
	task automatic t_route();
		issue(`SPC_SEL_PIN_CFG, 8'h00, 1'b0);
		issue(`SPC_SEL_STOP, 8'h04, 1'b0);
		`CHK(ind2, 1'b1)
		for (n = 0; n < 2; n++) begin
			i_busy = n[0];
			settle();
			`CHK(halt_a, n[0])
		end
		issue(`SPC_SEL_PIN_CFG, 8'h2F, 1'b0);
		`CHK({halt_a, ind2}, 2'b01)
		issue(`SPC_SEL_STOP, 8'h00, 1'b0);
		`CHK(ind2, 1'b0)
		$display("routing test done");
	endtask
	task automatic t_indicator();
		issue(`SPC_SEL_PIN_CFG, 8'h40, 1'b0);
		issue(`SPC_SEL_IND_CTRL, 8'h1C, 1'b0);
		for (n = 0; n < 8; n++) begin
			i_sect = spc_sect_s'(n[2:0]);
			settle();
			`CHK({ind1, ind2}, n[2:1])
		end
		issue(`SPC_SEL_IND_CTRL, 8'h04, 1'b0);
		i_sect = '0;
		settle();
		`CHK(ind1, 1'b1)
		issue(`SPC_SEL_IND_CTRL, 8'h00, 1'b0);
		issue(`SPC_SEL_STOP, 8'h04, 1'b0);
		`CHK({ind1, ind2}, 2'b01)
		i_sect.vol = 1'b1;
		settle();
		`CHK(ind1, 1'b1)
		issue(`SPC_SEL_PIN_CFG, 8'hC0, 1'b0);
		`CHK({ind1, ind2}, 2'b00)
		issue(`SPC_SEL_IND_CTRL, 8'h20, 1'b0);
		`CHK({ind1, ind2}, 2'b01)
		$display("indicator test done");
	endtask
	task automatic t_entry();
		for (n = 0; n < 4; n++) issue(4'(n), 8'h40 + 8'(n), 1'b0);
		`CHK({e0, e1, e2, e3}, 32'h40414243)
		issue(`SPC_SEL_ENTRY0, 8'hFE, 1'b0);
		issue(`SPC_SEL_ENTRY0, 8'h00, 1'b1);
		`CHK(e0, 8'hFF)
		issue(`SPC_SEL_ENTRY0, 8'h00, 1'b1);
		`CHK({e0, e1}, 16'h0041)
		issue(`SPC_SEL_PAGE, 8'hFF, 1'b0);
		`CHK(o_page, 5'h00)
		`CHK({pe, pm, bo}, {9'h100, 2'h0, 3'h2})
		$display("entry test done");
	endtask
	task automatic t_trig();
		issue(`SPC_SEL_EN_A, 8'h01, 1'b0);
		issue(`SPC_SEL_EN_B, 8'h21, 1'b0);
		board.set_buttons(4'h1);
		exp_vec(6'h00, n);
		`CHK(n >= `SPC_DEB_SHORT_CYC, 1'b1)
		board.set_buttons(4'h0);
		no_vec();
		`CHK(lvl, 4'hF)
		board.set_buttons(4'hC);
		exp_vec(6'h08, n);
		no_vec();
		board.set_buttons(4'h0);
		exp_vec(6'h0D, n);
		issue(`SPC_SEL_EN_A, 8'h33, 1'b0);
		board.set_buttons(4'h3);
		exp_vec(6'h00, n);
		exp_vec(6'h01, n);
		board.set_buttons(4'h0);
		exp_vec(6'h04, n);
		exp_vec(6'h05, n);
		i_jump_vec = 6'h2A;
		i_jump_req = 1'b1;
		exp_vec(6'h2A, n);
		board.set_buttons(4'h1);
		for (n = 0; n < DEB && o_vec.vector === 6'h2A; n++) @(negedge i_ref_clk);
		`CHK(o_vec, 7'h40)
		i_jump_req = 1'b0;
		issue(`SPC_SEL_EN_A, 8'hCC, 1'b0);
		board.set_buttons(4'h0);
		no_vec();
		$display("trigger test done");
	endtask
	initial begin
		repeat (6) @(negedge i_ref_clk);
		i_rstn = 1'b1;
		t_reset();
		t_stop();
		t_route();
		t_indicator();
		t_entry();
		t_trig();
		close_out();
	end
endmodule
`default_nettype wire
